/* rtl/adp_pkg.sv */
// Package of offsets, field positions, reset values and codes of the path.
package adp_pkg;

   // ------------------------------------------------------------------
   // Bus widths.
   // ------------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // ------------------------------------------------------------------
   // Register offsets.
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_LINK_CONTROL_0 = 8'h00;
   localparam logic [7:0] OFS_ZONE_FIELD = 8'h42;
   localparam logic [7:0] OFS_GAIN_VALUE = 8'h44;
   localparam logic [7:0] OFS_FILTER_MODE = 8'h4c;
   localparam logic [7:0] OFS_DECIMATION_CONTROL = 8'h4d;
   localparam logic [7:0] OFS_ZONE_SELECT_CONTROL = 8'h4e;
   localparam logic [7:0] OFS_GAIN_AND_REORDER_CONTROL = 8'h52;
   localparam logic [7:0] OFS_REORDER_CONTROL = 8'h72;
   localparam logic [7:0] OFS_LSB_OVERRIDE_ENABLE_REG = 8'hab;
   localparam logic [7:0] OFS_LSB_OVERRIDE_SELECT_REG = 8'had;
   localparam logic [7:0] OFS_LOGIC_RESET_CONTROL = 8'hf7;

   // ------------------------------------------------------------------
   // Field positions.
   // ------------------------------------------------------------------
   localparam int BIT_DEC_EN = 3;
   localparam int BIT_ZONE_EN = 7;
   localparam int BIT_GAIN_EN = 0;
   localparam int BIT_REORDER_A = 7;
   localparam int BIT_REORDER_B = 3;
   localparam int BIT_LSB_EN = 0;
   localparam int BIT_BLOCK_RESET = 0;
   localparam int BIT_FILT_HI = 4;
   localparam int BIT_LINK_FRAMES = 7;
   localparam int BIT_LINK_PATTERN = 4;
   localparam int BIT_LINK_FLIP = 3;
   localparam int BIT_LINK_LANE = 2;
   localparam int BIT_LINK_FRAME = 1;
   localparam int BIT_LINK_NOSEQ = 0;
   localparam logic [7:0] LINK_RW_MASK = 8'h9f;

   // ------------------------------------------------------------------
   // Reset values.
   // ------------------------------------------------------------------
   localparam logic [7:0] RST_LINK = 8'h00;
   localparam logic [3:0] RST_FILTER_MODE = 4'h2;
   localparam logic [2:0] RST_ZONE = 3'h0;
   localparam logic [6:0] RST_GAIN = 7'h00;
   localparam logic [1:0] RST_LSB_SEL = 2'h0;

   // ------------------------------------------------------------------
   // Codes.
   // ------------------------------------------------------------------
   localparam logic [3:0] FILT_LOWPASS = 4'ha;
   localparam logic [3:0] FILT_HIGHPASS = 4'he;
   localparam logic [2:0] ZONE_FIRST = 3'h0;
   localparam logic [2:0] ZONE_SECOND = 3'h1;
   localparam logic [2:0] ZONE_THIRD = 3'h2;
   localparam logic [1:0] LSB_FULL_DATA = 2'h0;
   localparam logic [1:0] LSB_FAST_FLAG = 2'h3;

   // Nyquist zone as decoded for the interleaving correction.
   typedef enum logic [1:0] {
      ZONE_NONE,
      ZONE_1,
      ZONE_2,
      ZONE_3
   } adp_zone_e;

endpackage : adp_pkg

/* rtl/adp_dp_if.sv */
// Interface carrying control from the register bank to the data path.
`timescale 1ns/1ps
interface adp_dp_if;
   logic override_en;
   logic block_reset;

   modport ctrl (output override_en, output block_reset);
   modport dpath (input override_en, input block_reset);
endinterface : adp_dp_if

/* rtl/adp_lsb_path.sv */
// Per-channel output stage that can swap the data LSB for the fast flag.
`timescale 1ns/1ps
module adp_lsb_path #(
   parameter int CH = 2,
   parameter int DW = 16
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   adp_dp_if.dpath cfg,
   input wire logic [CH*DW-1:0] ch_data_in,
   input wire logic [CH-1:0] fast_overrange_flag_in,
   output logic [CH*DW-1:0] ch_data_out
);

   logic [CH*DW-1:0] data_d;
   logic [CH*DW-1:0] data_q;

   // ------------------------------------------------------------------
   // Channel stage.
   // ------------------------------------------------------------------

   // Each channel takes its own flag; the block reset clears the stage.
   for (genvar c = 0; c < CH; c++) begin : g_ch
      always_comb begin
         if (cfg.block_reset) begin
            data_d[c*DW +: DW] = '0;
         end else if (cfg.override_en) begin
            data_d[c*DW +: DW] = {ch_data_in[c*DW+1 +: DW-1],
               fast_overrange_flag_in[c]};
         end else begin
            data_d[c*DW +: DW] = ch_data_in[c*DW +: DW];
         end
      end
   end

   // Registers the channel words.
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         data_q <= '0;
      end else begin
         data_q <= data_d;
      end
   end

   assign ch_data_out = data_q;

endmodule : adp_lsb_path

/* rtl/adp_config_regs.sv */
// Configuration registers of the converter's main digital data path.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module adp_config_regs #(
   parameter int CH = 2,
   parameter int DW = 16
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic [adp_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic [adp_pkg::DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [adp_pkg::DATA_W-1:0] reg_rdata_out,
   input wire logic [CH*DW-1:0] ch_data_in,
   input wire logic [CH-1:0] fast_overrange_flag_in,
   output logic [CH*DW-1:0] ch_data_out,
   output logic filter_highpass_out,
   output logic filter_mode_bad_out,
   output logic [1:0] zone_out,
   output logic [6:0] fine_gain_out,
   output logic bus_order_map_enable_out,
   output logic logic_block_reset_out,
   output logic frames_per_multiframe_ctrl_out,
   output logic transport_pattern_enable_out,
   output logic flip_data_out,
   output logic lane_align_insert_out,
   output logic frame_align_insert_out,
   output logic initial_sequence_disable_out
);

   // ------------------------------------------------------------------
   // Declarations.
   // ------------------------------------------------------------------
   logic [7:0] link_q, link_d;
   logic [3:0] filt_mode_q, filt_mode_d;
   logic decimation_ctrl_enable_q, decimation_ctrl_enable_d;
   logic [2:0] zone_field_q, zone_field_d;
   logic zone_en_q, zone_en_d;
   logic [6:0] gain_q, gain_d;
   logic fine_gain_enable_q, fine_gain_enable_d;
   logic reorder_a_q, reorder_a_d;
   logic reorder_b_q, reorder_b_d;
   logic lsb_en_q, lsb_en_d;
   logic [1:0] lsb_sel_q, lsb_sel_d;
   logic logic_block_reset_q, logic_block_reset_d;
   logic [7:0] rdata_q, rdata_d;
   logic filt_hp_q, filt_hp_d;
   logic filt_bad_q, filt_bad_d;
   adp_pkg::adp_zone_e zone_q, zone_d;
   logic [6:0] eff_gain_q, eff_gain_d;
   logic reorder_en_q, reorder_en_d;

   adp_dp_if dp ();

   // ------------------------------------------------------------------
   // Register writes.
   // ------------------------------------------------------------------

   // Computes the next register contents from a write strobe.
   always_comb begin
      link_d = link_q;
      filt_mode_d = filt_mode_q;
      decimation_ctrl_enable_d = decimation_ctrl_enable_q;
      zone_field_d = zone_field_q;
      zone_en_d = zone_en_q;
      gain_d = gain_q;
      fine_gain_enable_d = fine_gain_enable_q;
      reorder_a_d = reorder_a_q;
      reorder_b_d = reorder_b_q;
      lsb_en_d = lsb_en_q;
      lsb_sel_d = lsb_sel_q;
      logic_block_reset_d = 1'b0;
      if (reg_wr_in) begin
         case (reg_addr_in)
            adp_pkg::OFS_LINK_CONTROL_0: begin
               link_d = reg_wdata_in & adp_pkg::LINK_RW_MASK;
            end
            adp_pkg::OFS_FILTER_MODE: begin
               filt_mode_d = {reg_wdata_in[adp_pkg::BIT_FILT_HI],
                  reg_wdata_in[2:0]};
            end
            adp_pkg::OFS_DECIMATION_CONTROL: begin
               decimation_ctrl_enable_d =
                  reg_wdata_in[adp_pkg::BIT_DEC_EN];
            end
            adp_pkg::OFS_ZONE_FIELD: begin
               zone_field_d = reg_wdata_in[2:0];
            end
            adp_pkg::OFS_ZONE_SELECT_CONTROL: begin
               zone_en_d = reg_wdata_in[adp_pkg::BIT_ZONE_EN];
            end
            adp_pkg::OFS_GAIN_VALUE: begin
               gain_d = reg_wdata_in[6:0];
            end
            adp_pkg::OFS_GAIN_AND_REORDER_CONTROL: begin
               fine_gain_enable_d = reg_wdata_in[adp_pkg::BIT_GAIN_EN];
               reorder_a_d = reg_wdata_in[adp_pkg::BIT_REORDER_A];
            end
            adp_pkg::OFS_REORDER_CONTROL: begin
               reorder_b_d = reg_wdata_in[adp_pkg::BIT_REORDER_B];
            end
            adp_pkg::OFS_LSB_OVERRIDE_ENABLE_REG: begin
               lsb_en_d = reg_wdata_in[adp_pkg::BIT_LSB_EN];
            end
            adp_pkg::OFS_LSB_OVERRIDE_SELECT_REG: begin
               lsb_sel_d = reg_wdata_in[1:0];
            end
            adp_pkg::OFS_LOGIC_RESET_CONTROL: begin
               logic_block_reset_d =
                  reg_wdata_in[adp_pkg::BIT_BLOCK_RESET];
            end
            default: begin
               link_d = link_q;
            end
         endcase
      end
   end

   // Holds the register contents.
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         link_q <= adp_pkg::RST_LINK;
         filt_mode_q <= adp_pkg::RST_FILTER_MODE;
         decimation_ctrl_enable_q <= 1'b0;
         zone_field_q <= adp_pkg::RST_ZONE;
         zone_en_q <= 1'b0;
         gain_q <= adp_pkg::RST_GAIN;
         fine_gain_enable_q <= 1'b0;
         reorder_a_q <= 1'b0;
         reorder_b_q <= 1'b0;
         lsb_en_q <= 1'b0;
         lsb_sel_q <= adp_pkg::RST_LSB_SEL;
         logic_block_reset_q <= 1'b0;
      end else begin
         link_q <= link_d;
         filt_mode_q <= filt_mode_d;
         decimation_ctrl_enable_q <= decimation_ctrl_enable_d;
         zone_field_q <= zone_field_d;
         zone_en_q <= zone_en_d;
         gain_q <= gain_d;
         fine_gain_enable_q <= fine_gain_enable_d;
         reorder_a_q <= reorder_a_d;
         reorder_b_q <= reorder_b_d;
         lsb_en_q <= lsb_en_d;
         lsb_sel_q <= lsb_sel_d;
         logic_block_reset_q <= logic_block_reset_d;
      end
   end

   // ------------------------------------------------------------------
   // Register reads.
   // ------------------------------------------------------------------

   // Selects read data; write-only bits and unmapped offsets give zero.
   always_comb begin
      rdata_d = 8'h00;
      if (reg_rd_in) begin
         case (reg_addr_in)
            adp_pkg::OFS_LINK_CONTROL_0: begin
               rdata_d = link_q;
            end
            adp_pkg::OFS_FILTER_MODE: begin
               rdata_d[adp_pkg::BIT_FILT_HI] = filt_mode_q[3];
               rdata_d[2:0] = filt_mode_q[2:0];
            end
            adp_pkg::OFS_DECIMATION_CONTROL: begin
               rdata_d[adp_pkg::BIT_DEC_EN] = decimation_ctrl_enable_q;
            end
            adp_pkg::OFS_ZONE_FIELD: begin
               rdata_d[2:0] = zone_field_q;
            end
            adp_pkg::OFS_ZONE_SELECT_CONTROL: begin
               rdata_d[adp_pkg::BIT_ZONE_EN] = zone_en_q;
            end
            adp_pkg::OFS_GAIN_VALUE: begin
               rdata_d[6:0] = gain_q;
            end
            adp_pkg::OFS_GAIN_AND_REORDER_CONTROL: begin
               rdata_d[adp_pkg::BIT_GAIN_EN] = fine_gain_enable_q;
            end
            adp_pkg::OFS_LSB_OVERRIDE_ENABLE_REG: begin
               rdata_d[adp_pkg::BIT_LSB_EN] = lsb_en_q;
            end
            adp_pkg::OFS_LSB_OVERRIDE_SELECT_REG: begin
               rdata_d[1:0] = lsb_sel_q;
            end
            default: begin
               rdata_d = 8'h00;
            end
         endcase
      end
   end

   // Read data stands only in the cycle after the read strobe.
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata_out = rdata_q;

   // ------------------------------------------------------------------
   // Effective settings.
   // ------------------------------------------------------------------

   // Decodes the gated settings seen by the data path.
   always_comb begin
      filt_hp_d = 1'b0;
      filt_bad_d = 1'b0;
      if (decimation_ctrl_enable_q) begin
         case (filt_mode_q)
            adp_pkg::FILT_LOWPASS: begin
               filt_hp_d = 1'b0;
            end
            adp_pkg::FILT_HIGHPASS: begin
               filt_hp_d = 1'b1;
            end
            default: begin
               filt_bad_d = 1'b1;
            end
         endcase
      end
      zone_d = adp_pkg::ZONE_NONE;
      if (zone_en_q) begin
         case (zone_field_q)
            adp_pkg::ZONE_FIRST: zone_d = adp_pkg::ZONE_1;
            adp_pkg::ZONE_SECOND: zone_d = adp_pkg::ZONE_2;
            adp_pkg::ZONE_THIRD: zone_d = adp_pkg::ZONE_3;
            default: zone_d = adp_pkg::ZONE_NONE;
         endcase
      end
      eff_gain_d = fine_gain_enable_q ? gain_q : 7'h00;
      reorder_en_d = reorder_a_q & reorder_b_q;
   end

   // Registers the settings; the zone is outside the block reset.
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         filt_hp_q <= 1'b0;
         filt_bad_q <= 1'b0;
         zone_q <= adp_pkg::ZONE_NONE;
         eff_gain_q <= 7'h00;
         reorder_en_q <= 1'b0;
      end else begin
         filt_hp_q <= filt_hp_d;
         filt_bad_q <= filt_bad_d;
         zone_q <= zone_d;
         eff_gain_q <= eff_gain_d;
         reorder_en_q <= reorder_en_d;
      end
   end

   assign filter_highpass_out = filt_hp_q;
   assign filter_mode_bad_out = filt_bad_q;
   assign zone_out = zone_q;
   assign fine_gain_out = eff_gain_q;
   assign bus_order_map_enable_out = reorder_en_q;
   assign logic_block_reset_out = logic_block_reset_q;

   // Link control bits drive the serial link directly.
   assign frames_per_multiframe_ctrl_out = link_q[adp_pkg::BIT_LINK_FRAMES];
   assign transport_pattern_enable_out = link_q[adp_pkg::BIT_LINK_PATTERN];
   assign flip_data_out = link_q[adp_pkg::BIT_LINK_FLIP];
   assign lane_align_insert_out = link_q[adp_pkg::BIT_LINK_LANE];
   assign frame_align_insert_out = link_q[adp_pkg::BIT_LINK_FRAME];
   assign initial_sequence_disable_out =
      link_q[adp_pkg::BIT_LINK_NOSEQ];

   // ------------------------------------------------------------------
   // Data path.
   // ------------------------------------------------------------------

   // Override needs both the enable and the flag code.
   assign dp.override_en = lsb_en_q &&
      (lsb_sel_q == adp_pkg::LSB_FAST_FLAG);
   assign dp.block_reset = logic_block_reset_q;

   adp_lsb_path #(
      .CH(CH),
      .DW(DW)
   ) u_lsb_path (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .cfg(dp.dpath),
      .ch_data_in(ch_data_in),
      .fast_overrange_flag_in(fast_overrange_flag_in),
      .ch_data_out(ch_data_out)
   );

endmodule : adp_config_regs

/* testbench/adp_config_regs_asserts.sv */
// Checker of the configuration register bank at its ports.
`timescale 1ns/1ps
module adp_config_regs_asserts #(
   parameter int CH = 2,
   parameter int DW = 16
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic [adp_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic [adp_pkg::DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [adp_pkg::DATA_W-1:0] reg_rdata_out,
   input wire logic [CH*DW-1:0] ch_data_in,
   input wire logic [CH*DW-1:0] ch_data_out,
   input wire logic filter_highpass_out,
   input wire logic filter_mode_bad_out,
   input wire logic [1:0] zone_out,
   input wire logic [6:0] fine_gain_out,
   input wire logic bus_order_map_enable_out,
   input wire logic logic_block_reset_out,
   input wire logic frames_per_multiframe_ctrl_out,
   input wire logic transport_pattern_enable_out,
   input wire logic flip_data_out,
   input wire logic lane_align_insert_out,
   input wire logic frame_align_insert_out,
   input wire logic initial_sequence_disable_out
);
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (rst_in);

   // Write of a one to the block reset bit.
   wire logic kick = reg_wr_in && reg_wdata_in[0] &&
      reg_addr_in == adp_pkg::OFS_LOGIC_RESET_CONTROL;
   // Strobe and offset as one word passed in, so that the checks see the
   // sampled strobe and not the one launched at the same edge.
   wire logic [8:0] wr_addr = {reg_wr_in, reg_addr_in};
   // Write strobe aimed at a given offset.
   function automatic logic hit(input logic [8:0] wa,
                                input logic [7:0] ofs);
      return wa == {1'b1, ofs};
   endfunction : hit

   a_read_idle_zero: assert property (
      !$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
      else $error("read data present without a read");
   a_pulse_follows: assert property (kick |=> logic_block_reset_out)
      else $error("block reset pulse missing");
   a_pulse_single: assert property (
      logic_block_reset_out && !kick |=> !logic_block_reset_out)
      else $error("block reset did not clear itself");
   a_pulse_source: assert property (
      logic_block_reset_out |-> $past(kick))
      else $error("block reset without a write");
   a_data_flush: assert property (
      logic_block_reset_out |=> ch_data_out == '0)
      else $error("data path not reset");
   a_data_upper: assert property (
      !logic_block_reset_out |=>
      ch_data_out[DW-1:1] == $past(ch_data_in[DW-1:1]))
      else $error("upper data bits altered");
   a_gain_off: assert property (
      hit(wr_addr, adp_pkg::OFS_GAIN_AND_REORDER_CONTROL)
      && !reg_wdata_in[0] |-> ##2 fine_gain_out == 7'h00)
      else $error("gain applied while disabled");
   a_zone_off: assert property (
      hit(wr_addr, adp_pkg::OFS_ZONE_SELECT_CONTROL)
      && !reg_wdata_in[7] |-> ##2 zone_out == 2'h0)
      else $error("zone used while disabled");
   a_filter_off: assert property (
      hit(wr_addr, adp_pkg::OFS_DECIMATION_CONTROL) && !reg_wdata_in[3]
      |-> ##2 !(filter_highpass_out || filter_mode_bad_out))
      else $error("filter mode applied while disabled");
   a_order_pair: assert property (
      hit(wr_addr, adp_pkg::OFS_REORDER_CONTROL)
      && !reg_wdata_in[3] |-> ##2 !bus_order_map_enable_out)
      else $error("reorder enabled by one bit");
   a_link_bits: assert property (
      hit(wr_addr, adp_pkg::OFS_LINK_CONTROL_0) |=>
      {frames_per_multiframe_ctrl_out, transport_pattern_enable_out,
       flip_data_out, lane_align_insert_out, frame_align_insert_out,
       initial_sequence_disable_out} ==
      {$past(reg_wdata_in[7]), $past(reg_wdata_in[4:0])})
      else $error("link control outputs differ from write");

   // Main scenarios reached.
   c_pulse: cover property (logic_block_reset_out);
   c_highpass: cover property (filter_highpass_out);
   c_zone3: cover property (zone_out == 2'h3);
   c_order: cover property (bus_order_map_enable_out);
endmodule : adp_config_regs_asserts

bind adp_config_regs adp_config_regs_asserts #(.CH(CH), .DW(DW)) i_chk (
   .ref_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
   .reg_rd_in, .reg_rdata_out, .ch_data_in, .ch_data_out,
   .filter_highpass_out, .filter_mode_bad_out, .zone_out, .fine_gain_out,
   .bus_order_map_enable_out, .logic_block_reset_out,
   .frames_per_multiframe_ctrl_out, .transport_pattern_enable_out,
   .flip_data_out, .lane_align_insert_out, .frame_align_insert_out,
   .initial_sequence_disable_out);

/* testbench/adp_config_regs_tb_top.sv */
// Self-checking testbench of the configuration register bank.
`timescale 1ns/1ps
module adp_config_regs_tb_top;
   logic ref_clk_in, rst_in, reg_wr_in, reg_rd_in;
   logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
   logic [31:0] ch_data_in, ch_data_out;
   logic [1:0] fast_overrange_flag_in, zone_out;
   logic [6:0] fine_gain_out;
   logic filter_highpass_out, filter_mode_bad_out, bus_order_map_enable_out;
   logic logic_block_reset_out;
   wire [5:0] link_out;
   logic [7:0] b;
   int n_errors, n_tests, cycles;
   // Full words, and the same with each LSB swapped for its flag.
   localparam logic [31:0] FULL = 32'h1234_5679;
   localparam logic [31:0] REPL = 32'h1235_5678;

   adp_config_regs #(.CH(2), .DW(16)) i_dut (
      .ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
      .ch_data_in(ch_data_in), .fast_overrange_flag_in(fast_overrange_flag_in),
      .ch_data_out(ch_data_out), .filter_highpass_out(filter_highpass_out),
      .filter_mode_bad_out(filter_mode_bad_out), .zone_out(zone_out),
      .fine_gain_out(fine_gain_out),
      .bus_order_map_enable_out(bus_order_map_enable_out),
      .logic_block_reset_out(logic_block_reset_out),
      .frames_per_multiframe_ctrl_out(link_out[5]),
      .transport_pattern_enable_out(link_out[4]),
      .flip_data_out(link_out[3]), .lane_align_insert_out(link_out[2]),
      .frame_align_insert_out(link_out[1]),
      .initial_sequence_disable_out(link_out[0]));

   // Clock of 5 ns period.
   initial begin
      ref_clk_in = 1'b0;
      forever #2.5 ref_clk_in = ~ref_clk_in;
   end

   // Hang guard: the tests need under two hundred cycles.
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         complete_run();
      end
   end

   // Counts a comparison and reports a mismatch.
   task automatic check(input string name, input logic [31:0] exp,
                        input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // One-cycle write strobe, changed just after an edge.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b0;
   endtask : wr

   // One-cycle read strobe; data are taken in the following cycle.
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge ref_clk_in);
      reg_rd_in <= 1'b0;
      #1 check($sformatf("read %h", a), {24'h0, exp}, {24'h0, reg_rdata_out});
   endtask : rd

   // Lets a write reach the decoded outputs.
   task automatic settle;
      repeat (2) @(posedge ref_clk_in);
      #1;
   endtask : settle

   // Programs enable and mode, then checks the decoded filter state.
   task automatic filt(input logic [7:0] en, input logic [7:0] mode,
                       input logic hp, input logic bad);
      wr(8'h4d, en);
      wr(8'h4c, mode);
      settle();
      check("filter", {30'h0, hp, bad},
            {30'h0, filter_highpass_out, filter_mode_bad_out});
   endtask : filt

   // Prints the counts and the verdict, then stops.
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : complete_run

   // Main sequence.
   initial begin
      rst_in = 1'b1;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      reg_addr_in = 8'h00;
      reg_wdata_in = 8'h00;
      ch_data_in = FULL;
      fast_overrange_flag_in = 2'b10;
      n_errors = 0;
      n_tests = 0;
      cycles = 0;
      repeat (4) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      // Reset values read back and an unmapped place reads zero.
      rd(8'h00, 8'h00);
      rd(8'h42, 8'h00);
      rd(8'h44, 8'h00);
      rd(8'h4c, 8'h02);
      rd(8'h4d, 8'h00);
      rd(8'h4e, 8'h00);
      rd(8'hab, 8'h00);
      rd(8'had, 8'h00);
      rd(8'h10, 8'h00);
      check("outputs", 32'h0, {hp_bad_zero(), 16'h0});
      // Filter mode only counts while enabled; both codes and a bad one.
      filt(8'h00, 8'h16, 1'b0, 1'b0);
      filt(8'h08, 8'h16, 1'b1, 1'b0);
      filt(8'h08, 8'h12, 1'b0, 1'b0);
      filt(8'h08, 8'h02, 1'b0, 1'b1);
      filt(8'h00, 8'h02, 1'b0, 1'b0);
      rd(8'h4c, 8'h02);
      // Zone field ignored while disabled, then codes 0 to 3 decoded.
      wr(8'h42, 8'h01);
      wr(8'h4e, 8'h00);
      settle();
      check("zone off", 32'h0, {30'h0, zone_out});
      wr(8'h4e, 8'h80);
      for (int c = 0; c < 4; c++) begin
         wr(8'h42, 8'(c));
         settle();
         check("zone", (c < 3) ? 32'(c + 1) : 32'h0, {30'h0, zone_out});
      end
      wr(8'h42, 8'h02);
      // Gain applied only while enabled.
      wr(8'h44, 8'h7f);
      wr(8'h52, 8'h00);
      settle();
      check("gain off", 32'h0, {25'h0, fine_gain_out});
      wr(8'h52, 8'h01);
      settle();
      check("gain on", 32'h7f, {25'h0, fine_gain_out});
      // Reordering needs both bits; both read back zero.
      wr(8'h52, 8'h81);
      settle();
      check("order one", 32'h0, {31'h0, bus_order_map_enable_out});
      wr(8'h72, 8'h08);
      settle();
      check("order both", 32'h1, {31'h0, bus_order_map_enable_out});
      rd(8'h72, 8'h00);
      rd(8'h52, 8'h01);
      wr(8'h72, 8'h00);
      settle();
      check("order off", 32'h0, {31'h0, bus_order_map_enable_out});
      // LSB swap needs the enable and code 11; codes 01 and 00 give full data.
      wr(8'had, 8'h03);
      settle();
      check("lsb gated", FULL, ch_data_out);
      wr(8'hab, 8'h01);
      settle();
      check("lsb flag", REPL, ch_data_out);
      rd(8'had, 8'h03);
      wr(8'had, 8'h01);
      settle();
      check("lsb code 01", FULL, ch_data_out);
      wr(8'had, 8'h00);
      settle();
      check("lsb full", FULL, ch_data_out);
      // Block reset pulses once, clears the path, keeps the settings.
      wr(8'hf7, 8'h01);
      #1 check("pulse", 32'h1, {31'h0, logic_block_reset_out});
      @(posedge ref_clk_in);
      #1 check("pulse end", 32'h0, {31'h0, logic_block_reset_out});
      check("flushed", 32'h0, ch_data_out);
      @(posedge ref_clk_in);
      #1 check("data back", FULL, ch_data_out);
      check("zone kept", 32'h3, {30'h0, zone_out});
      check("gain kept", 32'h7f, {25'h0, fine_gain_out});
      rd(8'hf7, 8'h00);
      // A written zero must not pulse in the cycle where a one would.
      wr(8'hf7, 8'h00);
      #1 check("no pulse", 32'h0, {31'h0, logic_block_reset_out});
      // Each link control bit alone, then all bits.
      for (int k = 0; k < 7; k++) begin
         b = (k == 6) ? 8'hff : ((k == 0) ? 8'h80 : (8'h20 >> k));
         wr(8'h00, b);
         settle();
         check("link", {26'h0, b[7], b[4:0]}, {26'h0, link_out});
         rd(8'h00, b & 8'h9f);
      end
      complete_run();
   end

   // Decoded settings, block reset and link_out[5:3] (not link_out[2:0]), expected zero after reset.
   function automatic logic [15:0] hp_bad_zero();
      return {filter_highpass_out, filter_mode_bad_out, zone_out,
              fine_gain_out, bus_order_map_enable_out,
              logic_block_reset_out, link_out[5:3]};
   endfunction : hp_bad_zero
endmodule : adp_config_regs_tb_top
